//--- logic/pif_pkg.sv
// package: register map, field positions and bus carriers for the irq flag block
package pif_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // register byte addresses
   localparam logic [ADDR_W-1:0] OFF_FLAGS     = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_PIN_SEL   = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_PORT_STAT = 8'h08;

   // field positions of peripheral_irq_request_0
   localparam int BIT_TMR = 5;
   localparam int BIT_IOC = 4;
   localparam int BIT_EXT = 0;
   localparam int FLAG_W  = 8;

   // hardware-set flags: index 0 external edge, index 1 timer zero
   localparam int NUM_HW_FLAGS         = 2;
   localparam int IDX_EXT              = 0;
   localparam int IDX_TMR              = 1;
   localparam int HW_FLAG_POS [NUM_HW_FLAGS] = '{BIT_EXT, BIT_TMR};

   // pin select register layout
   localparam int BIT_EDGE_RISING = 7;

   // reset values
   localparam logic [NUM_HW_FLAGS-1:0] HW_FLAGS_RESET   = 2'h0;
   localparam logic                    SUMMARY_RESET    = 1'h0;
   localparam logic                    EDGE_RISING_RST  = 1'h1;
   localparam logic [DATA_W-1:0]       RDATA_RESET      = 32'h0000_0000;
   localparam logic [DATA_W-1:0]       RDATA_UNMAPPED   = 32'h0000_0000;

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } pif_apb_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic              pready;
      logic              pslverr;
   } pif_apb_rsp_type;

   typedef struct packed {
      logic timer_zero_overflow_flag;
      logic change_detect_summary_flag;
      logic external_edge_irq_flag;
   } pif_flags_type;

endpackage : pif_pkg

//--- logic/pif_edge_detect.sv
// selected-pin edge detector feeding the external edge flag
`timescale 1ns/1ns
module pif_edge_detect #(
   parameter int NUM_PINS = 8,
   parameter int SEL_W    = 3
) (
   input  wire logic                mclk_i,
   input  wire logic                rst_b_i,
   input  wire logic [NUM_PINS-1:0] pins_i,
   input  wire logic [SEL_W-1:0]    sel_i,
   input  wire logic                rising_i,
   output logic                     edge_o
);
   import pif_pkg::*;

   logic             cur;
   logic             prev;
   logic [SEL_W-1:0] sel_q;
   logic             next_edge;

   assign cur = pins_i[sel_i]; // RULE_05

   // a select change compares two different pins, so that cycle is masked
   always_comb begin
      if (sel_i != sel_q) begin
         next_edge = 1'b0;
      end else if (rising_i) begin
         next_edge = cur & ~prev;
      end else begin
         next_edge = ~cur & prev;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         prev  <= 1'b0;
         sel_q <= '0;
      end else begin
         prev  <= cur;
         sel_q <= sel_i;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         edge_o <= 1'b0;
      end else begin
         edge_o <= next_edge;
      end
   end

   a_edge_pulse_sel: assert property ( // RULE_05
      @(posedge mclk_i) disable iff (!rst_b_i)
      (sel_i == sel_q) && rising_i && pins_i[sel_i] && !prev |=> edge_o)
      else $error("edge on selected pin gave no pulse");

endmodule : pif_edge_detect

//--- logic/pif_irq_flags.sv
// peripheral irq request flags: timer zero, change-detect summary, external edge
// Operation
// (RULE_01) timer overflow sets flag until software clears
// (RULE_02) summary flag read-only, writes ignored
// (RULE_03) summary is OR of port change flags
// (RULE_04) external event sets flag until software clears
// (RULE_05) external input taken from selected pin
// (RULE_06) flags set regardless of any enable
// (RULE_07) software clears stale flags before enabling
// (RULE_08) software clears port flags to clear summary
// (RULE_09) unimplemented bits read zero, ignore writes
`timescale 1ns/1ns
module pif_irq_flags #(
   parameter int NUM_PINS = 8,
   parameter int SEL_W    = 3,
   parameter int PORT_A_W = 8,
   parameter int PORT_E_W = 8
) (
   input  wire logic                     mclk_i,
   input  wire logic                     rst_b_i,
   input  wire pif_pkg::pif_apb_req_type apb_req_i,
   output pif_pkg::pif_apb_rsp_type      apb_rsp_o,
   input  wire logic                     timer_zero_overflow_i,
   input  wire logic [NUM_PINS-1:0]      gpio_i,
   input  wire logic [PORT_A_W-1:0]      port_a_change_flags_i,
   input  wire logic [PORT_E_W-1:0]      port_e_change_flags_i,
   output pif_pkg::pif_flags_type        flags_o
);
   import pif_pkg::*;

   logic [NUM_HW_FLAGS-1:0] hw_flag;
   logic [NUM_HW_FLAGS-1:0] next_hw_flag;
   logic [NUM_HW_FLAGS-1:0] set_vec;
   logic                    summary;
   logic                    next_summary;
   logic [SEL_W-1:0]        external_irq_pin_select;
   logic                    edge_rising;
   logic                    ext_pulse;
   logic                    setup;
   logic                    access;
   logic                    wr_flags;
   logic                    wr_pin_sel;
   logic                    mapped;
   logic [DATA_W-1:0]       next_rdata;

   function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] off);
      return a == off;
   endfunction : addr_hit

   // only implemented bits are placed; all others stay zero
   function automatic logic [FLAG_W-1:0] flag_word(input logic [NUM_HW_FLAGS-1:0] f,
                                                   input logic                    s);
      logic [FLAG_W-1:0] w;
      w          = '0;
      w[BIT_TMR] = f[IDX_TMR];
      w[BIT_IOC] = s;
      w[BIT_EXT] = f[IDX_EXT];
      return w;
   endfunction : flag_word

   // bus phases
   assign setup      = apb_req_i.psel & ~apb_req_i.penable;
   assign access     = apb_req_i.psel & apb_req_i.penable & apb_rsp_o.pready;
   assign wr_flags   = access & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, OFF_FLAGS);
   assign wr_pin_sel = access & apb_req_i.pwrite & addr_hit(apb_req_i.paddr, OFF_PIN_SEL);

   // external edge source
   pif_edge_detect #(
      .NUM_PINS (NUM_PINS),
      .SEL_W    (SEL_W)
   ) u_edge (
      .mclk_i   (mclk_i),
      .rst_b_i  (rst_b_i),
      .pins_i   (gpio_i),
      .sel_i    (external_irq_pin_select),
      .rising_i (edge_rising),
      .edge_o   (ext_pulse)
   );

   // no enable term anywhere: a condition always lands in its flag
   assign set_vec[IDX_EXT] = ext_pulse;             // RULE_04 RULE_06
   assign set_vec[IDX_TMR] = timer_zero_overflow_i; // RULE_01 RULE_06

   // write stores the bit, a same-cycle hardware set wins over a clear
   for (genvar g = 0; g < NUM_HW_FLAGS; g++) begin : g_flag
      assign next_hw_flag[g] = (wr_flags ? apb_req_i.pwdata[HW_FLAG_POS[g]] : hw_flag[g])
                               | set_vec[g]; // RULE_01 RULE_04

      always_ff @(posedge mclk_i or negedge rst_b_i) begin
         if (!rst_b_i) begin
            hw_flag[g] <= HW_FLAGS_RESET[g];
         end else begin
            hw_flag[g] <= next_hw_flag[g];
         end
      end
   end

   // summary follows the port flags only; bus writes never reach it
   assign next_summary = (|port_a_change_flags_i) | (|port_e_change_flags_i); // RULE_03

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         summary <= SUMMARY_RESET;
      end else begin
         summary <= next_summary; // RULE_02 RULE_03
      end
   end

   // pin select and edge sense
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         external_irq_pin_select <= '0;
         edge_rising             <= EDGE_RISING_RST;
      end else if (wr_pin_sel) begin
         external_irq_pin_select <= apb_req_i.pwdata[SEL_W-1:0]; // RULE_05
         edge_rising             <= apb_req_i.pwdata[BIT_EDGE_RISING];
      end
   end

   // flag outputs mirror the stored flags from their own flops
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         flags_o <= '0;
      end else begin
         flags_o.timer_zero_overflow_flag   <= next_hw_flag[IDX_TMR];
         flags_o.external_edge_irq_flag     <= next_hw_flag[IDX_EXT];
         flags_o.change_detect_summary_flag <= next_summary;
      end
   end

   // read decode
   always_comb begin
      mapped     = 1'b1;
      next_rdata = RDATA_UNMAPPED;
      if (addr_hit(apb_req_i.paddr, OFF_FLAGS)) begin
         next_rdata = DATA_W'(flag_word(hw_flag, summary)); // RULE_09
      end else if (addr_hit(apb_req_i.paddr, OFF_PIN_SEL)) begin
         next_rdata                  = DATA_W'(external_irq_pin_select);
         next_rdata[BIT_EDGE_RISING] = edge_rising;
      end else if (addr_hit(apb_req_i.paddr, OFF_PORT_STAT)) begin
         next_rdata = DATA_W'({port_e_change_flags_i, port_a_change_flags_i});
      end else begin
         mapped = 1'b0;
      end
   end

   // answer is fixed: ready in the first access cycle; read data caught at setup
   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         apb_rsp_o.pready  <= 1'b0;
         apb_rsp_o.pslverr <= 1'b0;
      end else begin
         apb_rsp_o.pready  <= setup;
         apb_rsp_o.pslverr <= setup & ~mapped;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         apb_rsp_o.prdata <= RDATA_RESET;
      end else if (setup & ~apb_req_i.pwrite) begin
         apb_rsp_o.prdata <= next_rdata;
      end
   end

   a_tmr_set_flag: assert property ( // RULE_01
      @(posedge mclk_i) disable iff (!rst_b_i)
      timer_zero_overflow_i |=> hw_flag[IDX_TMR] && flags_o.timer_zero_overflow_flag)
      else $error("timer overflow did not set its flag");

   a_tmr_flag_hold: assert property ( // RULE_01
      @(posedge mclk_i) disable iff (!rst_b_i)
      hw_flag[IDX_TMR] && !(wr_flags && !apb_req_i.pwdata[BIT_TMR]) |=> hw_flag[IDX_TMR])
      else $error("timer flag dropped without a clearing write");

   a_set_beats_clear: assert property ( // RULE_01
      @(posedge mclk_i) disable iff (!rst_b_i)
      timer_zero_overflow_i && wr_flags && !apb_req_i.pwdata[BIT_TMR] |=> hw_flag[IDX_TMR])
      else $error("clear won over a same-cycle timer overflow");

   a_ext_flag_hold: assert property ( // RULE_04
      @(posedge mclk_i) disable iff (!rst_b_i)
      ext_pulse ##1 !(wr_flags && !apb_req_i.pwdata[BIT_EXT])
      |-> hw_flag[IDX_EXT] ##1 hw_flag[IDX_EXT])
      else $error("external flag not set and held");

   a_summary_or: assert property ( // RULE_03
      @(posedge mclk_i) disable iff (!rst_b_i)
      ##1 summary == ($past(|port_a_change_flags_i) || $past(|port_e_change_flags_i)))
      else $error("summary flag differs from OR of port flags");

   a_summary_readonly: assert property ( // RULE_02
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_flags && $stable(port_a_change_flags_i) && $stable(port_e_change_flags_i)
      |=> $stable(summary))
      else $error("write disturbed the summary flag");

   a_read_flags: assert property ( // RULE_02 RULE_09
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup && !apb_req_i.pwrite && addr_hit(apb_req_i.paddr, OFF_FLAGS)
      |=> apb_rsp_o.prdata[BIT_IOC] == $past(summary)
          && apb_rsp_o.prdata[BIT_TMR] == $past(hw_flag[IDX_TMR])
          && apb_rsp_o.prdata[DATA_W-1:BIT_TMR+1] == '0
          && apb_rsp_o.prdata[BIT_IOC-1:BIT_EXT+1] == '0)
      else $error("flag read returned wrong or nonzero reserved bits");

   a_ready_timing: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup |=> apb_rsp_o.pready ##1 !apb_rsp_o.pready || setup)
      else $error("ready not given in first access cycle");

   a_pin_sel_write: assert property ( // RULE_05
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_pin_sel |=> external_irq_pin_select == $past(apb_req_i.pwdata[SEL_W-1:0]))
      else $error("pin select write not stored");

   a_pin_sense_write: assert property ( // RULE_05
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_pin_sel |=> edge_rising == $past(apb_req_i.pwdata[BIT_EDGE_RISING]))
      else $error("edge sense write not stored");

   a_pin_sel_hold: assert property ( // RULE_05
      @(posedge mclk_i) disable iff (!rst_b_i)
      !wr_pin_sel |=> $stable(external_irq_pin_select) && $stable(edge_rising))
      else $error("pin select changed without a write");

   // flag set and clear paths
   a_ext_set_flag: assert property ( // RULE_04
      @(posedge mclk_i) disable iff (!rst_b_i)
      ext_pulse |=> hw_flag[IDX_EXT] && flags_o.external_edge_irq_flag)
      else $error("external edge did not set its flag");

   a_tmr_clear_write: assert property ( // RULE_01
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_flags && !apb_req_i.pwdata[BIT_TMR] && !timer_zero_overflow_i |=> !hw_flag[IDX_TMR])
      else $error("clearing write left the timer flag set");

   a_ext_clear_write: assert property ( // RULE_04
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_flags && !apb_req_i.pwdata[BIT_EXT] && !ext_pulse |=> !hw_flag[IDX_EXT])
      else $error("clearing write left the external flag set");

   a_summary_write_one: assert property ( // RULE_02
      @(posedge mclk_i) disable iff (!rst_b_i)
      wr_flags && apb_req_i.pwdata[BIT_IOC] && !summary
      && !(|port_a_change_flags_i) && !(|port_e_change_flags_i) |=> !summary)
      else $error("write of one reached the summary flag");

   // outputs are separate flops, so they must track the stored state
   a_tmr_out_mirror: assert property ( // RULE_01
      @(posedge mclk_i) disable iff (!rst_b_i)
      flags_o.timer_zero_overflow_flag == hw_flag[IDX_TMR])
      else $error("timer flag output differs from stored flag");

   a_ext_out_mirror: assert property ( // RULE_04
      @(posedge mclk_i) disable iff (!rst_b_i)
      flags_o.external_edge_irq_flag == hw_flag[IDX_EXT])
      else $error("external flag output differs from stored flag");

   a_summary_out_mirror: assert property ( // RULE_03
      @(posedge mclk_i) disable iff (!rst_b_i)
      flags_o.change_detect_summary_flag == summary)
      else $error("summary output differs from stored summary");

   a_read_ext_bit: assert property ( // RULE_04
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup && !apb_req_i.pwrite && addr_hit(apb_req_i.paddr, OFF_FLAGS)
      |=> apb_rsp_o.prdata[BIT_EXT] == $past(hw_flag[IDX_EXT]))
      else $error("flag read returned a wrong external bit");

   a_read_pin_sel: assert property ( // RULE_05
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup && !apb_req_i.pwrite && addr_hit(apb_req_i.paddr, OFF_PIN_SEL)
      |=> apb_rsp_o.prdata[SEL_W-1:0] == $past(external_irq_pin_select)
          && apb_rsp_o.prdata[BIT_EDGE_RISING] == $past(edge_rising))
      else $error("pin select read returned wrong data");

   a_read_port_stat: assert property ( // RULE_03
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup && !apb_req_i.pwrite && addr_hit(apb_req_i.paddr, OFF_PORT_STAT)
      |=> apb_rsp_o.prdata[PORT_A_W-1:0] == $past(port_a_change_flags_i)
          && apb_rsp_o.prdata[PORT_A_W+PORT_E_W-1:PORT_A_W] == $past(port_e_change_flags_i))
      else $error("port status read returned wrong data");

   // bus response shape
   a_error_unmapped: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      setup |=> apb_rsp_o.pslverr == $past(!mapped))
      else $error("error response does not match the address decode");

   a_error_with_ready: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      apb_rsp_o.pslverr |-> apb_rsp_o.pready)
      else $error("error response without ready");

   a_ready_after_setup: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      apb_rsp_o.pready |-> $past(setup))
      else $error("ready without a preceding setup cycle");

   a_rdata_hold: assert property (
      @(posedge mclk_i) disable iff (!rst_b_i)
      !(setup && !apb_req_i.pwrite) |=> $stable(apb_rsp_o.prdata))
      else $error("read data changed outside a read setup");

endmodule : pif_irq_flags

//--- bench/pif_irq_flags_tb.sv
// self-checking bench for the irq flag block, driven over apb
`timescale 1ns/1ns
module pif_irq_flags_tb;
   import pif_pkg::*;

   localparam int LIMIT = 20000;

   logic            mclk;
   logic            rst_b;
   pif_apb_req_type req;
   pif_apb_rsp_type rsp;
   logic            tmr;
   logic [7:0]      gpio;
   logic [7:0]      pa;
   logic [7:0]      pe;
   pif_flags_type   flags;
   int              miscompares;
   int              cmp_count;
   int              cycles;
   logic [31:0]     rd;
   logic            err;
   int              k;

   pif_irq_flags #(
      .NUM_PINS (8),
      .SEL_W    (3),
      .PORT_A_W (8),
      .PORT_E_W (8)
   ) u_dut (
      .mclk_i                (mclk),
      .rst_b_i               (rst_b),
      .apb_req_i             (req),
      .apb_rsp_o             (rsp),
      .timer_zero_overflow_i (tmr),
      .gpio_i                (gpio),
      .port_a_change_flags_i (pa),
      .port_e_change_flags_i (pe),
      .flags_o               (flags)
   );

   always #5 mclk = ~mclk;

   task summarize();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   // hang guard: a stuck wait ends here as a failure
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         miscompares = miscompares + 1;
         summarize();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc

   // values read at the edge that samples pready, before that edge's updates land
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge mclk);
      req.penable <= 1'b1;
      do begin
         @(posedge mclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req <= '0;
   endtask : apb

   task rchk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, e);
      chk(32'(err), 32'h0000_0000);
   endtask : rchk

   initial begin
      mclk = 1'b0;
      rst_b = 1'b0;
      req = '0;
      tmr = 1'b0;
      gpio = 8'h00;
      pa = 8'h00;
      pe = 8'h00;
      miscompares = 0;
      cmp_count = 0;
      cycles = 0;
      repeat (16) @(posedge mclk);
      rst_b <= 1'b1;
      rchk(OFF_FLAGS, RDATA_RESET);
      rchk(OFF_PIN_SEL, 32'h0000_0080);
      // timer pulse latches until software writes zero
      @(posedge mclk);
      tmr <= 1'b1;
      @(posedge mclk);
      tmr <= 1'b0;
      cyc(2);
      chk(32'(flags.timer_zero_overflow_flag), 32'h0000_0001);
      cyc(20);
      rchk(OFF_FLAGS, 32'h0000_0020);
      apb(1'b1, OFF_FLAGS, 32'h0000_0000);
      rchk(OFF_FLAGS, 32'h0000_0000);
      // overflow on the very edge that lands a clearing write: the set must win
      fork
         apb(1'b1, OFF_FLAGS, 32'h0000_0000);
         begin
            cyc(2);
            tmr <= 1'b1;
            cyc(1);
            tmr <= 1'b0;
         end
      join
      rchk(OFF_FLAGS, 32'h0000_0020);
      // all ones: only the two writable flags may stick
      apb(1'b1, OFF_FLAGS, 32'hFFFF_FFFF);
      rchk(OFF_FLAGS, 32'h0000_0021);
      apb(1'b1, OFF_FLAGS, 32'h0000_0000);
      // each port change flag alone raises the summary
      for (k = 0; k < 16; k++) begin
         {pe, pa} <= 16'h0001 << k;
         cyc(2);
         chk(32'(flags.change_detect_summary_flag), 32'h0000_0001);
         apb(1'b1, OFF_FLAGS, 32'h0000_0000);
         rchk(OFF_FLAGS, 32'h0000_0010);
         rchk(OFF_PORT_STAT, 32'h0000_0001 << k);
      end
      {pe, pa} <= 16'h8001;
      cyc(2);
      pa <= 8'h00;
      cyc(2);
      chk(32'(flags.change_detect_summary_flag), 32'h0000_0001);
      pe <= 8'h00;
      cyc(2);
      chk(32'(flags.change_detect_summary_flag), 32'h0000_0000);
      // every pin select value, with a decoy edge on a neighbour pin
      for (k = 0; k < 8; k++) begin
         gpio <= 8'h00;
         cyc(3);
         apb(1'b1, OFF_PIN_SEL, 32'h0000_0080 | k);
         apb(1'b1, OFF_FLAGS, 32'h0000_0000);
         gpio[(k + 1) % 8] <= 1'b1;
         cyc(4);
         chk(32'(flags.external_edge_irq_flag), 32'h0000_0000);
         gpio[k] <= 1'b1;
         cyc(4);
         chk(32'(flags.external_edge_irq_flag), 32'h0000_0001);
         cyc(10);
         rchk(OFF_FLAGS, 32'h0000_0001);
      end
      // falling sense: rising edge ignored, falling edge sets
      gpio <= 8'h00;
      cyc(3);
      apb(1'b1, OFF_PIN_SEL, 32'h0000_0002);
      apb(1'b1, OFF_FLAGS, 32'h0000_0000);
      gpio[2] <= 1'b1;
      cyc(4);
      chk(32'(flags.external_edge_irq_flag), 32'h0000_0000);
      gpio[2] <= 1'b0;
      cyc(4);
      chk(32'(flags.external_edge_irq_flag), 32'h0000_0001);
      // unmapped address is refused with an error and zero data
      apb(1'b0, 8'h0C, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      chk(rd, RDATA_UNMAPPED);
      summarize();
   end

endmodule : pif_irq_flags_tb
